// [shared/mode_cfg_pkg.sv]
// Package: mode register field layout, encodings and timing constants
package mode_cfg_pkg;

  // ==========================================================
  // Command decode (cs, ras, cas, we all low = mode set)
  localparam logic [3:0] CMD_MODE_SET = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_SELF_REF = 4'h1;
  localparam logic [2:0] BANK_BURST_LATENCY = 3'h0;
  localparam logic [2:0] BANK_DLL_DRIVE = 3'h1;

  // ==========================================================
  // burst_latency_mode_reg fields
  localparam int BL_LSB = 0;
  localparam int CL_BIT2 = 2;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int TEST_BIT = 7;
  localparam int DLL_RST_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int PD_DLL_BIT = 12;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // ==========================================================
  // dll_drive_mode_reg fields, plus the chop address bit of read/write commands
  localparam int DLL_DIS_BIT = 0;
  localparam int DRV_BIT0 = 1;
  localparam int RTT_BIT0 = 2;
  localparam int AL_LSB = 3;
  localparam int DRV_BIT1 = 5;
  localparam int RTT_BIT1 = 6;
  localparam int RTT_BIT2 = 9;
  localparam int CHOP_LINE = 12;

  // ==========================================================
  // Reset values and counts
  localparam logic [14:0] MODE_RESET = 15'h0000;
  localparam logic [3:0] CHOP_PULL_IN = 4'h2;
  localparam logic [3:0] CWL_DEFAULT = 4'h5;
  localparam logic [3:0] TRP_CYCLES = 4'h5;
  localparam int DLL_LOCK_CYCLES = 512;

endpackage

// [src/burst_order.sv]
// Column order generator for one burst beat
`timescale 1ns/1ns
`default_nettype none

module burst_order (
  // Burst setup
  input wire logic [2:0] start_col_i,
  input wire logic interleave_i,
  input wire logic is_write_i,
  input wire logic chop_i,
  input wire logic [2:0] beat_i,
  // Result
  output logic [2:0] col_o,
  output logic hiz_o
);

  logic [1:0] low_sum;

  always_comb begin
    low_sum = start_col_i[1:0] + beat_i[1:0];
    hiz_o = 1'b0;
    if (is_write_i) begin
      if (chop_i) begin
        col_o = {start_col_i[2], beat_i[1:0]};
        hiz_o = beat_i[2];
      end else begin
        col_o = beat_i;
      end
    end else if (interleave_i) begin
      col_o = start_col_i ^ beat_i;
      hiz_o = chop_i & beat_i[2];
    end else begin
      col_o = {start_col_i[2] ^ beat_i[2], low_sum};
      hiz_o = chop_i & beat_i[2];
    end
  end

endmodule // burst_order

`default_nettype wire

// [src/dram_mode_burst_dll_config.sv]
// Mode register decode, burst sequencing and DLL state of the memory device
// Contract
// - Burst type bit selects sequential (0) or interleaved (1) order.
// - Burst length comes from bits 1:0: fixed four, fixed eight, or on-the-fly.
// - Sequential reads rotate low two column bits, then visit the other nibble.
// - Interleaved read beat n is start column XOR n.
// - Chopped reads float data and strobe for the last four beat slots.
// - Writes ignore low column bits; chop picks nibble by column bit two.
// - Fixed chop starts internal write two clocks earlier; on-the-fly does not. Here early_write_o pulses one link clock before the first write beat.
// - DLL reset bit clears itself once the reset has been performed.
// - Write recovery field bits 11:9 plus precharge time set auto-precharge delay.
// - Power-down DLL bit zero freezes the DLL in precharge power-down.
// - Power-down DLL bit one keeps the DLL running in precharge power-down.
// - Enabled DLL switches off in self-refresh and back on after it.
// - Write termination applies during writes even with nominal off.
// - Driver impedance selected by bits 1 and 5 of DLL/drive register.
// - Commands held for added latency; read and write latency include it.
// - Writes need no DLL unless write termination is enabled.
// - CAS latency in whole clocks from bits 2 and 6:4.
`timescale 1ns/1ns
`default_nettype none

module dram_mode_burst_dll_config (
  // System side
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Command link, clocked by the controller's clock
  input wire logic clk_link_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] bank_i,
  input wire logic [14:0] addr_i,
  // Device state inputs
  input wire logic self_refresh_i,
  input wire logic precharge_pd_i,
  input wire logic write_term_en_i,
  // Burst beat outputs (link domain)
  output logic [2:0] beat_col_o,
  output logic beat_valid_o,
  output logic data_hiz_o,
  output logic is_write_o,
  output logic early_write_o,
  // Configuration outputs (system domain)
  output logic dll_running_o,
  output logic dll_locked_o,
  output logic [1:0] drive_sel_o,
  output logic [3:0] cas_latency_o,
  output logic [4:0] read_latency_o,
  output logic [4:0] write_latency_o,
  output logic [4:0] autopre_delay_o,
  output logic write_dll_needed_o
);

  // ==========================================================
  // Link domain: command capture and burst sequencing
  typedef struct packed {
    logic [14:0] burst_latency_mode_reg;
    logic [14:0] dll_drive_mode_reg;
    logic [3:0] hold_cnt;
    logic pend;
    logic pend_write;
    logic pend_chop;
    logic [2:0] pend_col;
    logic active;
    logic act_write;
    logic act_chop;
    logic [2:0] start_col;
    logic [2:0] beat;
    logic [2:0] beat_col;
    logic beat_valid;
    logic data_hiz;
    logic is_write;
    logic early_write;
    logic dll_rst_tgl;
  } link_state_t;

  link_state_t link_reg, link_next;
  logic [1:0] rst_link_sync;
  logic [2:0] col_now;
  logic hiz_now;
  logic [3:0] cmd;
  logic [1:0] bl_code;
  logic chop_sel;
  logic [3:0] cl_link;
  logic [3:0] al_hold;

  always_ff @(posedge clk_link_i) begin
    rst_link_sync <= {rst_link_sync[0], rst_i};
  end

  burst_order u_order (
    .start_col_i(link_reg.start_col),
    .interleave_i(link_reg.burst_latency_mode_reg[mode_cfg_pkg::BT_BIT]),
    .is_write_i(link_reg.act_write),
    .chop_i(link_reg.act_chop),
    .beat_i(link_reg.beat),
    .col_o(col_now),
    .hiz_o(hiz_now)
  );

  always_comb begin
    link_next = link_reg;
    cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
    bl_code = link_reg.burst_latency_mode_reg[mode_cfg_pkg::BL_LSB +: 2];
    // Added latency counts whole link clocks, derived from CAS latency
    cl_link = {link_reg.burst_latency_mode_reg[mode_cfg_pkg::CL_LSB +: 3],
               link_reg.burst_latency_mode_reg[mode_cfg_pkg::CL_BIT2]} +
              4'h4;
    unique case (link_reg.dll_drive_mode_reg[mode_cfg_pkg::AL_LSB +: 2])
      2'h1: al_hold = cl_link - 4'h1;
      2'h2: al_hold = cl_link - 4'h2;
      default: al_hold = 4'h0;
    endcase
    // Reserved length code behaves as eight beats
    chop_sel = (bl_code == mode_cfg_pkg::BL_FIXED4) ||
               ((bl_code == mode_cfg_pkg::BL_OTF) &&
                !addr_i[mode_cfg_pkg::CHOP_LINE]);
    link_next.early_write = 1'b0;
    if (cmd == mode_cfg_pkg::CMD_MODE_SET) begin
      if (bank_i == mode_cfg_pkg::BANK_BURST_LATENCY) begin
        link_next.burst_latency_mode_reg = addr_i;
        // Self-clearing: the reset request leaves as a toggle only
        link_next.burst_latency_mode_reg[mode_cfg_pkg::DLL_RST_BIT] = 1'b0;
        if (addr_i[mode_cfg_pkg::DLL_RST_BIT]) begin
          link_next.dll_rst_tgl = ~link_reg.dll_rst_tgl;
        end
      end else if (bank_i == mode_cfg_pkg::BANK_DLL_DRIVE) begin
        link_next.dll_drive_mode_reg = addr_i;
      end
    end else if ((cmd == mode_cfg_pkg::CMD_READ) ||
                 (cmd == mode_cfg_pkg::CMD_WRITE)) begin
      // Held for the added latency before issuing internally
      link_next.pend = 1'b1;
      link_next.pend_write = (cmd == mode_cfg_pkg::CMD_WRITE);
      link_next.pend_chop = chop_sel;
      link_next.pend_col = addr_i[2:0];
      link_next.hold_cnt = al_hold;
    end
    if (link_reg.pend && (cmd != mode_cfg_pkg::CMD_READ) &&
        (cmd != mode_cfg_pkg::CMD_WRITE)) begin
      if (link_reg.hold_cnt != 4'h0) begin
        link_next.hold_cnt = link_reg.hold_cnt - 4'h1;
      end else begin
        link_next.pend = 1'b0;
        link_next.active = 1'b1;
        link_next.act_write = link_reg.pend_write;
        link_next.act_chop = link_reg.pend_chop;
        link_next.start_col = link_reg.pend_col;
        link_next.beat = 3'h0;
        // Only a programmed fixed chop pulls the internal write in
        link_next.early_write = link_reg.pend_write &&
          (bl_code == mode_cfg_pkg::BL_FIXED4);
      end
    end
    link_next.beat_valid = link_reg.active;
    link_next.beat_col = col_now;
    link_next.data_hiz = link_reg.active & hiz_now;
    link_next.is_write = link_reg.act_write;
    if (link_reg.active) begin
      link_next.beat = link_reg.beat + 3'h1;
      if (link_reg.beat == 3'h7) begin
        link_next.active = 1'b0;
      end
    end
    if (rst_link_sync[1]) begin
      link_next = '0;
      link_next.burst_latency_mode_reg = mode_cfg_pkg::MODE_RESET;
      link_next.dll_drive_mode_reg = mode_cfg_pkg::MODE_RESET;
    end
  end

  always_ff @(posedge clk_link_i) begin
    link_reg <= link_next;
  end

  assign beat_col_o = link_reg.beat_col;
  assign beat_valid_o = link_reg.beat_valid;
  assign data_hiz_o = link_reg.data_hiz;
  assign is_write_o = link_reg.is_write;
  assign early_write_o = link_reg.early_write;

  // ==========================================================
  // System domain: DLL control and derived latencies
  // Mode words are quasi-static: the controller leaves the lock time
  // and mode delays before using them, so a two-stage copy suffices.
  typedef struct packed {
    logic [14:0] mr0_s1;
    logic [14:0] mr0_s2;
    logic [14:0] mr1_s1;
    logic [14:0] mr1_s2;
    logic [2:0] tgl_sync;
    logic [2:0] sr_sync;
    logic [1:0] pd_sync;
    logic [1:0] wt_sync;
    logic [9:0] lock_cnt;
    logic dll_running;
    logic dll_locked;
    logic [1:0] drive_sel;
    logic [3:0] cas_latency;
    logic [4:0] read_latency;
    logic [4:0] write_latency;
    logic [4:0] autopre_delay;
    logic write_dll_needed;
  } sys_state_t;

  sys_state_t sys_reg, sys_next;
  logic [3:0] cl_val;
  logic [3:0] wr_val;
  logic [4:0] al_val;
  logic dll_enabled;
  logic dll_frozen;

  always_comb begin
    sys_next = sys_reg;
    sys_next.mr0_s1 = link_reg.burst_latency_mode_reg;
    sys_next.mr0_s2 = sys_reg.mr0_s1;
    sys_next.mr1_s1 = link_reg.dll_drive_mode_reg;
    sys_next.mr1_s2 = sys_reg.mr1_s1;
    sys_next.tgl_sync = {sys_reg.tgl_sync[1:0], link_reg.dll_rst_tgl};
    sys_next.sr_sync = {sys_reg.sr_sync[1:0], self_refresh_i};
    sys_next.pd_sync = {sys_reg.pd_sync[0], precharge_pd_i};
    sys_next.wt_sync = {sys_reg.wt_sync[0], write_term_en_i};
    // Whole-clock CAS latency, code 1 maps to 5 clocks
    cl_val = {sys_reg.mr0_s2[mode_cfg_pkg::CL_LSB +: 3],
              sys_reg.mr0_s2[mode_cfg_pkg::CL_BIT2]} + 4'h4;
    wr_val = {1'b0, sys_reg.mr0_s2[mode_cfg_pkg::WR_LSB +: 3]} + 4'h4;
    unique case (sys_reg.mr1_s2[mode_cfg_pkg::AL_LSB +: 2])
      2'h1: al_val = {1'b0, cl_val} - 5'h1;
      2'h2: al_val = {1'b0, cl_val} - 5'h2;
      default: al_val = 5'h0;
    endcase
    dll_enabled = !sys_reg.mr1_s2[mode_cfg_pkg::DLL_DIS_BIT];
    dll_frozen = sys_reg.pd_sync[1] &&
      !sys_reg.mr0_s2[mode_cfg_pkg::PD_DLL_BIT];
    sys_next.dll_running = dll_enabled && !sys_reg.sr_sync[1] &&
      !dll_frozen;
    if (sys_reg.tgl_sync[2] != sys_reg.tgl_sync[1]) begin
      sys_next.lock_cnt = 10'h000;
      sys_next.dll_locked = 1'b0;
    end else if (!sys_next.dll_running) begin
      sys_next.dll_locked = 1'b0;
    end else if (!sys_reg.dll_locked && sys_reg.dll_running) begin
      sys_next.lock_cnt = sys_reg.lock_cnt + 10'h001;
      if (sys_reg.lock_cnt ==
          10'(mode_cfg_pkg::DLL_LOCK_CYCLES - 1)) begin
        sys_next.dll_locked = 1'b1;
      end
    end
    sys_next.drive_sel = {sys_reg.mr1_s2[mode_cfg_pkg::DRV_BIT1],
                          sys_reg.mr1_s2[mode_cfg_pkg::DRV_BIT0]};
    sys_next.cas_latency = cl_val;
    sys_next.read_latency = al_val + {1'b0, cl_val};
    sys_next.write_latency = al_val +
      {1'b0, mode_cfg_pkg::CWL_DEFAULT};
    sys_next.autopre_delay = {1'b0, wr_val} +
      {1'b0, mode_cfg_pkg::TRP_CYCLES};
    sys_next.write_dll_needed = sys_reg.wt_sync[1];
    if (rst_i) begin
      sys_next = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    sys_reg <= sys_next;
  end

  assign dll_running_o = sys_reg.dll_running;
  assign dll_locked_o = sys_reg.dll_locked;
  assign drive_sel_o = sys_reg.drive_sel;
  assign cas_latency_o = sys_reg.cas_latency;
  assign read_latency_o = sys_reg.read_latency;
  assign write_latency_o = sys_reg.write_latency;
  assign autopre_delay_o = sys_reg.autopre_delay;
  assign write_dll_needed_o = sys_reg.write_dll_needed;

endmodule // dram_mode_burst_dll_config

`default_nettype wire

// [test/ctrl_model.sv]
// Command-side model of the memory controller
`timescale 1ns/1ns
`default_nettype none
module ctrl_model (
  // Link clock
  input wire logic clk_link_i,
  // Command pins
  output logic [3:0] cmd_n_o,
  output logic [2:0] bank_o,
  output logic [14:0] addr_o
);
  initial begin
    cmd_n_o = 4'hf;
    bank_o = 3'h0;
    addr_o = 15'h0000;
  end
  // Deselected lines show the inverse, so a stale copy is never decoded
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
    input logic [14:0] a);
    @(posedge clk_link_i);
    cmd_n_o <= c;
    bank_o <= b;
    addr_o <= a;
    @(posedge clk_link_i);
    cmd_n_o <= {1'b1, ~c[2:0]};
    bank_o <= ~b;
    addr_o <= ~a;
  endtask
  // Clock enable never drops and write termination stays off
  // Test bit kept at zero; a recovery setting of six covers the recovery time
  task automatic set_burst(input logic pd, input logic [1:0] bl,
    input logic bt, input logic dll_rst);
    cmd(mode_cfg_pkg::CMD_MODE_SET, mode_cfg_pkg::BANK_BURST_LATENCY,
      {2'h0, pd, 3'h2, dll_rst, 1'b0, 3'h2, bt, 1'b0, bl});
    repeat (4) @(posedge clk_link_i);
  endtask
  task automatic set_dll(input logic [14:0] a);
    cmd(mode_cfg_pkg::CMD_MODE_SET, mode_cfg_pkg::BANK_DLL_DRIVE, a);
    repeat (4) @(posedge clk_link_i);
  endtask
endmodule // ctrl_model
`default_nettype wire

// [test/dram_mode_assertions.sv]
// Port-level checker for the mode, burst and DLL block
`timescale 1ns/1ns
`default_nettype none
module dram_mode_checker (
  // Clocks and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_link_i,
  // Watched inputs
  input wire logic write_term_en_i,
  // Beat outputs
  input wire logic [2:0] beat_col_o,
  input wire logic beat_valid_o,
  input wire logic data_hiz_o,
  input wire logic is_write_o,
  input wire logic early_write_o,
  // Config outputs
  input wire logic dll_locked_o,
  input wire logic [3:0] cas_latency_o,
  input wire logic [4:0] read_latency_o,
  input wire logic [4:0] write_latency_o,
  input wire logic write_dll_needed_o
);
  // ==========
  // Lock may only rise after a long stretch low
  logic [9:0] low_cnt_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || dll_locked_o) low_cnt_reg <= 10'h000;
    else if (low_cnt_reg != 10'h3ff) low_cnt_reg <= low_cnt_reg + 10'h001;
  end
  chk_beat_span: assert property (@(posedge clk_link_i)
    disable iff (rst_i) $rose(beat_valid_o) |-> beat_valid_o [*8] ##1
    !beat_valid_o) else $error("burst is not eight beats");
  chk_hiz_tail: assert property (@(posedge clk_link_i)
    disable iff (rst_i) $rose(data_hiz_o) |->
    (data_hiz_o && beat_valid_o) [*4] ##1 !beat_valid_o)
    else $error("float slots not the last four");
  chk_write_start: assert property (@(posedge clk_link_i)
    disable iff (rst_i) $rose(beat_valid_o) && is_write_o |->
    beat_col_o[1:0] == 2'h0) else $error("write burst not nibble aligned");
  chk_write_step: assert property (@(posedge clk_link_i)
    disable iff (rst_i) beat_valid_o && $past(beat_valid_o) && is_write_o
    && !data_hiz_o |-> beat_col_o[1:0] == $past(beat_col_o[1:0]) + 2'h1)
    else $error("write column not stepping");
  chk_early_write: assert property (@(posedge clk_link_i)
    disable iff (rst_i) early_write_o |-> ##[0:3]
    (beat_valid_o && is_write_o)) else $error("early pulse without write");
  chk_lat_pair: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) cas_latency_o != 4'h0 |->
    write_latency_o + cas_latency_o == read_latency_o + 5'h05)
    else $error("read and write latency disagree");
  chk_lock_wait: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) $rose(dll_locked_o) |-> low_cnt_reg >= 10'h1f4)
    else $error("lock came too early");
  chk_term_dll: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) write_term_en_i [*6] |-> write_dll_needed_o)
    else $error("write termination without DLL need");
  cov_chop: cover property (@(posedge clk_link_i) $rose(data_hiz_o));
  cov_early: cover property (@(posedge clk_link_i) early_write_o);
  cov_lock: cover property (@(posedge clk_sys_i) $rose(dll_locked_o));
endmodule // dram_mode_checker
bind dram_mode_burst_dll_config dram_mode_checker chk (.clk_sys_i, .rst_i,
  .clk_link_i, .write_term_en_i, .beat_col_o, .beat_valid_o, .data_hiz_o,
  .is_write_o, .early_write_o, .dll_locked_o, .cas_latency_o,
  .read_latency_o, .write_latency_o, .write_dll_needed_o);
`default_nettype wire

// [test/dram_mode_burst_dll_config_tb.sv]
// Self-checking bench for the mode, burst and DLL block
`timescale 1ns/1ns
`default_nettype none
module dram_mode_burst_dll_config_tb;
  logic clk_sys_i = 1'b0, clk_link_i = 1'b0, rst_i = 1'b1;
  logic self_refresh_i = 1'b0, precharge_pd_i = 1'b0, write_term_en_i = 1'b0;
  logic cs_n_i, ras_n_i, cas_n_i, we_n_i;
  logic [2:0] bank_i, beat_col_o;
  logic [14:0] addr_i;
  logic beat_valid_o, data_hiz_o, is_write_o, early_write_o;
  logic dll_running_o, dll_locked_o, write_dll_needed_o;
  logic [1:0] drive_sel_o;
  logic [3:0] cas_latency_o;
  logic [4:0] read_latency_o, write_latency_o, autopre_delay_o;
  int num_errors = 0, check_count = 0, early_cnt = 0, lat = 0, i, m, w, s;
  always #25 clk_sys_i = ~clk_sys_i;
  initial begin
    #3;
    forever #16 clk_link_i = ~clk_link_i;
  end
  always @(negedge clk_link_i) if (early_write_o === 1'b1) early_cnt++;
  ctrl_model ctl (.clk_link_i, .cmd_n_o({cs_n_i, ras_n_i, cas_n_i, we_n_i}),
    .bank_o(bank_i), .addr_o(addr_i));
  dram_mode_burst_dll_config DUT (.clk_sys_i, .rst_i, .clk_link_i, .cs_n_i,
    .ras_n_i, .cas_n_i, .we_n_i, .bank_i, .addr_i, .self_refresh_i,
    .precharge_pd_i, .write_term_en_i, .beat_col_o, .beat_valid_o,
    .data_hiz_o, .is_write_o, .early_write_o, .dll_running_o, .dll_locked_o,
    .drive_sel_o, .cas_latency_o, .read_latency_o, .write_latency_o,
    .autopre_delay_o, .write_dll_needed_o);
  // ==========
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic sys_wait(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic sys_set(input logic sr, input logic pd, input logic wt);
    @(posedge clk_sys_i);
    {self_refresh_i, precharge_pd_i, write_term_en_i} <= {sr, pd, wt};
    sys_wait(10);
  endtask
  function automatic logic [2:0] exp_col(input logic wr, input logic il,
    input logic ch, input logic [2:0] st, input logic [2:0] n);
    if (wr) return ch ? {st[2], n[1:0]} : n;
    if (il) return st ^ n;
    return {st[2] ^ n[2], st[1:0] + n[1:0]};
  endfunction
  // Lat counts link cycles from command to first beat
  task automatic burst(input logic wr, input logic ch, input logic il,
    input logic a12, input logic [2:0] st, input logic ew);
    int k;
    early_cnt = 0;
    ctl.cmd(wr ? mode_cfg_pkg::CMD_WRITE : mode_cfg_pkg::CMD_READ, 3'h0,
      {2'h0, a12, 9'h000, st});
    lat = 0;
    do begin
      @(negedge clk_link_i);
      lat++;
    end while (beat_valid_o !== 1'b1 && lat < 40);
    for (k = 0; k < 8; k++) begin
      if (!(ch && k > 3)) check(8'(beat_col_o), 8'(exp_col(wr, il, ch, st, 3'(k))));
      check(8'({beat_valid_o, is_write_o, data_hiz_o}), 8'({1'b1, wr, ch && k > 3}));
      @(negedge clk_link_i);
    end
    check(8'({beat_valid_o, early_cnt[1:0]}), 8'({1'b0, 1'b0, ew}));
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_link_i);
    ctl.set_dll(15'h0028);
    ctl.set_burst(1'b1, mode_cfg_pkg::BL_FIXED8, 1'b0, 1'b1);
    sys_wait(20);
    check(8'(cas_latency_o), 8'h08);
    check(8'(read_latency_o), 8'h0f);
    check(8'(write_latency_o), 8'h0c);
    check(8'(autopre_delay_o), 8'h0b);
    check(8'({drive_sel_o, dll_running_o, dll_locked_o}), 8'h0a);
    i = 0;
    while (dll_locked_o !== 1'b1 && i < 700) begin
      sys_wait(1);
      i++;
    end
    check(8'({dll_locked_o, i + 24 > mode_cfg_pkg::DLL_LOCK_CYCLES}), 8'h03);
    sys_set(1'b0, 1'b1, 1'b0);
    check(8'(dll_running_o), 8'h01);
    ctl.set_burst(1'b0, mode_cfg_pkg::BL_FIXED8, 1'b0, 1'b0);
    sys_wait(20);
    check(8'(dll_running_o), 8'h00);
    sys_set(1'b1, 1'b0, 1'b0);
    check(8'({dll_running_o, write_dll_needed_o}), 8'h00);
    sys_set(1'b0, 1'b0, 1'b1);
    check(8'({dll_running_o, write_dll_needed_o}), 8'h03);
    sys_set(1'b0, 1'b0, 1'b0);
    burst(1'b0, 1'b0, 1'b0, 1'b1, 3'h5, 1'b0);
    s = lat;
    ctl.set_dll(15'h0020);
    burst(1'b0, 1'b0, 1'b0, 1'b1, 3'h5, 1'b0);
    check(8'(s - lat), 8'h07);
    for (m = 0; m < 10; m++) begin
      ctl.set_burst(1'b1, m < 2 ? mode_cfg_pkg::BL_FIXED8 : m < 4 ?
        mode_cfg_pkg::BL_FIXED4 : m < 8 ? mode_cfg_pkg::BL_OTF : 2'h3,
        1'(m), 1'b0);
      for (w = 0; w < 16; w++) burst(1'(w / 8), m / 2 == 1 || m / 2 == 3, 1'(m), 1'(m / 2 == 2), 3'(w), 1'(w / 8 == 1 && m / 2 == 1));
    end
    conclude();
  end
  initial begin
    repeat (10000) @(posedge clk_sys_i);
    num_errors++;
    conclude();
  end
endmodule // dram_mode_burst_dll_config_tb
`default_nettype wire
